/* design/btm_cfg.svh */
// Constants for the board test mode controller.
`ifndef BTM_CFG_SVH
`define BTM_CFG_SVH

// Strap order: {p146, p103, p29, p50, p100, p108, p145, p94}.
`define BTM_STRAP_W        8
`define BTM_ENTRY_PATTERN  8'hC0
`define BTM_STRAP_146_BIT  7

// Counts of pads in each group.
`define BTM_NAND_W         133
`define BTM_OUT_W          138
`define BTM_HELD_W         7

// Held pads in order 161, 163, 167, 180, 181, 183, 184; a set bit marks an odd pin.
`define BTM_HELD_ODD       7'h37

// Bit positions inside the control synchroniser vector.
`define BTM_CTL_W          11
`define BTM_CTL_PG_BIT     10
`define BTM_CTL_P65_BIT    9
`define BTM_CTL_SEL_BIT    8

`endif

/* design/btm_pkg.sv */
// Types shared by the board test mode controller.
`default_nettype none
package btm_pkg;
   typedef enum logic [1:0] {
      BTM_NORMAL = 2'h0,
      BTM_FLOAT  = 2'h1,
      BTM_DRIVE  = 2'h3
   } btm_mode_t;
endpackage : btm_pkg
`default_nettype wire

/* design/btm_sync.sv */
// Three-stage pin synchroniser with a two-stage agreement filter.
`default_nettype none
module btm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // Pin side
   input  wire logic [W-1:0] async_in,
   // Clock side
   output logic      [W-1:0] filt_q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // The first stage feeds only the second, so metastability never reaches logic.
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               s1_r[i]   <= 1'b0;
               s2_r[i]   <= 1'b0;
               s3_r[i]   <= 1'b0;
               filt_q[i] <= 1'b0;
            end else begin
               s1_r[i] <= async_in[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               if (s2_r[i] == s3_r[i]) begin
                  filt_q[i] <= s3_r[i];
               end
            end
         end
      end
   endgenerate
endmodule : btm_sync
`default_nettype wire

/* design/btm_top.sv */
// Board test mode controller: entry latch, tristate, NAND tree and drive patterns.
`include "btm_cfg.svh"
`default_nettype none
module btm_top
   import btm_pkg::*;
#(
   parameter int                        NAND_W   = `BTM_NAND_W,
   parameter int                        OUT_W    = `BTM_OUT_W,
   parameter int                        HELD_W   = `BTM_HELD_W,
   parameter logic [OUT_W-1:0]          ODD_MASK = {(OUT_W/2){2'b10}},
   parameter logic [HELD_W-1:0]         HELD_ODD = `BTM_HELD_ODD
) (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   // Entry pins
   input  wire logic                    test_sel_pin,
   input  wire logic [`BTM_STRAP_W-1:0] strap_pins,
   input  wire logic                    sense65_pin,
   input  wire logic                    power_good_input,
   // NAND tree inputs in chain order, pin 206 first
   input  wire logic [NAND_W-1:0]       nand_pins,
   // Functional values from the core for the testable pads
   input  wire logic [OUT_W-1:0]        core_out,
   input  wire logic [OUT_W-1:0]        core_oe,
   // Functional values from the core for the always driven pads
   input  wire logic [HELD_W-1:0]       core_held_out,
   input  wire logic [HELD_W-1:0]       core_held_oe,
   // Functional value from the core for pin 25
   input  wire logic                    core_res_out,
   input  wire logic                    core_res_oe,
   // Testable pads
   output logic      [OUT_W-1:0]        pad_out,
   output logic      [OUT_W-1:0]        pad_oe,
   // Always driven pads
   output logic      [HELD_W-1:0]       held_out,
   output logic      [HELD_W-1:0]       held_oe,
   // Pin 25
   output logic                         nand_res_out,
   output logic                         nand_res_oe,
   // Status
   output logic                         test_mode,
   output btm_mode_t                    test_func
);
   logic [`BTM_CTL_W-1:0]   ctl_q;
   logic [NAND_W-1:0]       nand_q;
   logic [NAND_W-1:0]       chain;
   logic                    sel_q;
   logic                    sel_d_r;
   logic                    pg_q;
   logic                    pg_d_r;
   logic                    p65_q;
   logic                    sel_rise;
   logic                    pg_rise;
   logic                    strap_ok;
   logic                    pg_ok_r;
   logic                    test_mode_r;
   logic                    test_mode_nxt;
   btm_mode_t               mode_r;
   btm_mode_t               mode_nxt;

   // Drive pattern level for one pad: 146 low drives odd pins low, 146 high drives them high.
   function automatic logic pattern_bit(input logic sel146, input logic is_odd);
      pattern_bit = ~(sel146 ^ is_odd);
   endfunction : pattern_bit

   function automatic logic entry_match(input logic [`BTM_STRAP_W-1:0] straps);
      entry_match = (straps == `BTM_ENTRY_PATTERN);
   endfunction : entry_match

   btm_sync #(.W(`BTM_CTL_W)) u_ctl_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in ({power_good_input, sense65_pin, test_sel_pin, strap_pins}),
      .filt_q   (ctl_q)
   );

   // The chain is sampled through the same filter, so the result lags the pins by a few cycles.
   btm_sync #(.W(NAND_W)) u_nand_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in (nand_pins),
      .filt_q   (nand_q)
   );

   assign sel_q    = ctl_q[`BTM_CTL_SEL_BIT];
   assign pg_q     = ctl_q[`BTM_CTL_PG_BIT];
   assign p65_q    = ctl_q[`BTM_CTL_P65_BIT];
   assign sel_rise = sel_q & ~sel_d_r;
   assign pg_rise  = pg_q & ~pg_d_r;
   // Straps and select share one filter, so they are seen at the same edge.
   assign strap_ok = entry_match(ctl_q[`BTM_STRAP_W-1:0]);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sel_d_r <= 1'b0;
         pg_d_r  <= 1'b0;
      end else begin
         sel_d_r <= sel_q;
         pg_d_r  <= pg_q;
      end
   end

   // Pin 65 is judged only at the power-good rise and held until the next one.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pg_ok_r <= 1'b0;
      end else if (pg_rise) begin
         pg_ok_r <= p65_q;
      end
   end

   // Every select rise re-judges the straps, so a bad pattern also leaves test mode.
   always_comb begin
      test_mode_nxt = test_mode_r;
      if (sel_rise) begin
         test_mode_nxt = strap_ok && pg_ok_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         test_mode_r <= 1'b0;
      end else begin
         test_mode_r <= test_mode_nxt;
      end
   end

   always_comb begin
      mode_nxt = BTM_NORMAL;
      if (test_mode_r) begin
         mode_nxt = sel_q ? BTM_FLOAT : BTM_DRIVE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_r <= BTM_NORMAL;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   genvar i;
   generate
      assign chain[0] = nand_q[0];
      for (i = 1; i < NAND_W; i++) begin : g_chain
         assign chain[i] = ~(chain[i-1] & nand_q[i]);
      end
   endgenerate

   // Testable pads.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pad_out <= '0;
         pad_oe  <= '0;
      end else begin
         unique case (mode_r)
            BTM_NORMAL: begin
               pad_out <= core_out;
               pad_oe  <= core_oe;
            end
            BTM_FLOAT: begin
               pad_out <= '0;
               pad_oe  <= '0;
            end
            BTM_DRIVE: begin
               for (int k = 0; k < OUT_W; k++) begin
                  pad_out[k] <= pattern_bit(ctl_q[`BTM_STRAP_146_BIT], ODD_MASK[k]);
               end
               pad_oe <= '1;
            end
            default: begin
               pad_out <= '0;
               pad_oe  <= '0;
            end
         endcase
      end
   end

   // Held pads pass the core values, also in the float test; they take the pattern only in the drive test.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         held_out <= '0;
         held_oe  <= '0;
      end else if (mode_r == BTM_DRIVE) begin
         for (int k = 0; k < HELD_W; k++) begin
            held_out[k] <= pattern_bit(ctl_q[`BTM_STRAP_146_BIT], HELD_ODD[k]);
         end
         held_oe <= '1;
      end else begin
         held_out <= core_held_out;
         held_oe  <= core_held_oe;
      end
   end

   // Pin 25 carries the chain while the testable pads float.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         nand_res_out <= 1'b0;
         nand_res_oe  <= 1'b0;
      end else if (mode_r == BTM_FLOAT) begin
         nand_res_out <= chain[NAND_W-1];
         nand_res_oe  <= 1'b1;
      end else begin
         nand_res_out <= core_res_out;
         nand_res_oe  <= core_res_oe;
      end
   end

   assign test_mode = test_mode_r;
   assign test_func = mode_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_enter;
      sel_rise && strap_ok && pg_ok_r;
   endsequence

   sequence s_reject;
      sel_rise && !(strap_ok && pg_ok_r);
   endsequence

   a_entry_taken: assert property (s_enter |=> test_mode_r)
      else $error("Test mode not entered on valid strap capture.");
   a_entry_refused: assert property (s_reject |=> !test_mode_r)
      else $error("Test mode entered with a bad strap capture.");
   a_mode_holds: assert property (!sel_rise |=> $stable(test_mode_r))
      else $error("Test mode changed without a select rise.");
   a_pg_sample: assert property (pg_rise |=> pg_ok_r == $past(p65_q))
      else $error("Pin 65 level not captured at power-good rise.");
   a_enter_float: assert property (s_enter ##1 sel_q |=> mode_r == BTM_FLOAT)
      else $error("Float test not selected after entry with select high.");
   a_float_pads: assert property (mode_r == BTM_FLOAT |=> pad_oe == '0)
      else $error("Testable pad driven during tristate test.");
   a_keep_driving: assert property (mode_r == BTM_FLOAT |=> held_oe == $past(core_held_oe))
      else $error("Held pad released during tristate test.");
   a_nand_result: assert property (mode_r == BTM_FLOAT |=>
                                   nand_res_oe && nand_res_out == $past(chain[NAND_W-1]))
      else $error("NAND tree result not driven on pin 25.");
   a_drive_pattern: assert property (mode_r == BTM_DRIVE |=> pad_oe == '1 &&
      pad_out == ($past(ctl_q[`BTM_STRAP_146_BIT]) ? ODD_MASK : ~ODD_MASK))
      else $error("Drive pattern wrong for pin 146 level.");
   a_normal_pass: assert property (!test_mode_r ##1 !test_mode_r |=>
                                   pad_out == $past(core_out) && pad_oe == $past(core_oe))
      else $error("Pads not passing core values in normal operation.");
endmodule : btm_top
`default_nettype wire

/* testbench/btm_ate.sv */
// Tester model that drives the entry pins of the test mode controller.
`default_nettype none
module btm_ate (
   // Clock
   input  wire logic       ref_clk,
   // Requested pin levels
   input  wire logic [7:0] req_strap,
   input  wire logic       req_p65,
   input  wire logic       req_pg,
   input  wire logic       req_sel,
   // Pins
   output logic      [7:0] strap_pins = 8'h00,
   output logic            sense65_pin = 1'b0,
   output logic            power_good_input = 1'b0,
   output logic            test_sel_pin = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins move only just after an edge, as a tester strobes its drivers.
   always @(posedge ref_clk) begin
      strap_pins       <= req_strap;
      sense65_pin      <= req_p65;
      power_good_input <= req_pg;
      test_sel_pin     <= req_sel;
   end
endmodule : btm_ate
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the board test mode controller.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import btm_pkg::*;
   localparam logic [137:0] ODD = {69{2'b10}};
   localparam logic [6:0]   HODD = 7'h37;
   logic         ref_clk, rst_n;
   logic [7:0]   rq_s = 8'h00;
   logic         rq_p65 = 1'b0, rq_pg = 1'b0, rq_sel = 1'b0;
   logic [7:0]   strap;
   logic         p65, pg, sel, nres_out, nres_oe, tmode;
   logic [132:0] nand_in = '1;
   logic [137:0] c_out = {69{2'b01}}, c_oe = {69{2'b11}}, p_out, p_oe;
   logic [6:0]   ch_out = 7'h5A, ch_oe = 7'h6C, h_out, h_oe;
   logic         c_res = 1'b1, c_res_oe = 1'b0;
   btm_mode_t    tfunc;
   int           n_errors = 0, tests_run = 0, cyc = 0;

   btm_ate ATE (.ref_clk(ref_clk), .req_strap(rq_s), .req_p65(rq_p65), .req_pg(rq_pg),
      .req_sel(rq_sel), .strap_pins(strap), .sense65_pin(p65), .power_good_input(pg),
      .test_sel_pin(sel));
   btm_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .test_sel_pin(sel), .strap_pins(strap),
      .sense65_pin(p65), .power_good_input(pg), .nand_pins(nand_in), .core_out(c_out),
      .core_oe(c_oe), .core_held_out(ch_out), .core_held_oe(ch_oe), .core_res_out(c_res),
      .core_res_oe(c_res_oe), .pad_out(p_out), .pad_oe(p_oe), .held_out(h_out),
      .held_oe(h_oe), .nand_res_out(nres_out), .nand_res_oe(nres_oe), .test_mode(tmode),
      .test_func(tfunc));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // The hang guard sits well above the roughly 175 cycles the tests use.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 1000) begin
         n_errors++;
         $display("ERROR %0t timeout", $time);
         print_verdict();
      end
   end

   // Wide enough for a full pad word joined with the held pads.
   task automatic chk(input logic [144:0] got, input logic [144:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask : chk

   // Waits past the filter and output pipeline, then samples off the edge.
   task automatic settle();
      repeat (12) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic pins(input logic [7:0] s, input logic p, input logic g, input logic e);
      @(posedge ref_clk);
      rq_s   <= s;
      rq_p65 <= p;
      rq_pg  <= g;
      rq_sel <= e;
      settle();
   endtask : pins

   task automatic t_bad();
      pins(8'hC0, 1'b1, 1'b1, 1'b0);
      pins(8'h80, 1'b1, 1'b1, 1'b0);
      pins(8'h80, 1'b1, 1'b1, 1'b1);
      chk(tmode, 1'b0, "bad straps entered");
      chk(tfunc, BTM_NORMAL, "mode not normal");
      chk(p_out, c_out, "pads not passed");
      chk({nres_oe, nres_out}, {c_res_oe, c_res}, "pin 25 not passed");
      $display("test bad_straps done");
   endtask : t_bad

   task automatic t_entry();
      pins(8'hC0, 1'b1, 1'b1, 1'b0);
      pins(8'hC0, 1'b1, 1'b1, 1'b1);
      chk(tmode, 1'b1, "no entry");
      chk(tfunc, BTM_FLOAT, "not float");
      chk(p_oe, '0, "pads driven");
      chk({h_oe, h_out}, {ch_oe, ch_out}, "held pads");
      chk(nres_oe, 1'b1, "result pin floats");
      $display("test entry done");
   endtask : t_entry

   task automatic t_nand();
      logic [132:0] pat [3];
      logic         exp [3];
      pat = '{'1, {{132{1'b1}}, 1'b0}, ~(133'h1 << 131)};
      exp = '{1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         nand_in <= pat[i];
         settle();
         chk(nres_out, exp[i], "chain result");
      end
      $display("test nand done");
   endtask : t_nand

   task automatic t_drive();
      pins(8'hC0, 1'b1, 1'b1, 1'b0);
      chk(tfunc, BTM_DRIVE, "not drive");
      chk({p_oe, h_oe}, '1, "drive enables");
      chk({p_out, h_out}, {ODD, HODD}, "odd high");
      pins(8'h40, 1'b1, 1'b1, 1'b0);
      chk({p_out, h_out}, {~ODD, ~HODD}, "even high");
      chk(tmode, 1'b1, "mode lost");
      $display("test drive done");
   endtask : t_drive

   task automatic t_pg();
      pins(8'hC0, 1'b0, 1'b0, 1'b0);
      pins(8'hC0, 1'b0, 1'b1, 1'b0);
      pins(8'hC0, 1'b0, 1'b1, 1'b1);
      chk(tmode, 1'b0, "entry without pin 65");
      chk(p_oe, c_oe, "enables not passed");
      $display("test power_good done");
   endtask : t_pg

   initial begin
      rst_n = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_bad();
      t_entry();
      t_nand();
      t_drive();
      t_pg();
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
